// ---- sct_pkg.sv ----
// constants, enumerations and state layout for the instruction timing core
// assumes a single core clock where one machine cycle is one clock period
package sct_pkg;

	localparam int SCT_OPC_W    = 8;
	localparam int SCT_LEN_W    = 2;
	localparam int SCT_CYC_W    = 4;
	localparam int SCT_WAIT_W   = 3;
	localparam int SCT_RETIRE_W = 16;

	// instruction lengths in bytes
	localparam logic [SCT_LEN_W-1:0] SCT_LEN_0 = 2'h0;
	localparam logic [SCT_LEN_W-1:0] SCT_LEN_1 = 2'h1;
	localparam logic [SCT_LEN_W-1:0] SCT_LEN_2 = 2'h2;
	localparam logic [SCT_LEN_W-1:0] SCT_LEN_3 = 2'h3;

	// execution times in core clocks
	localparam logic [SCT_CYC_W-1:0] SCT_CYC_1      = 4'h1;
	localparam logic [SCT_CYC_W-1:0] SCT_CYC_2      = 4'h2;
	localparam logic [SCT_CYC_W-1:0] SCT_CYC_3      = 4'h3;
	localparam logic [SCT_CYC_W-1:0] SCT_CYC_4      = 4'h4;
	localparam logic [SCT_CYC_W-1:0] SCT_CYC_MULDIV = 4'h9;
	localparam logic [SCT_CYC_W-1:0] SCT_CYC_XMOVE  = 4'h4;
	localparam logic [SCT_CYC_W-1:0] SCT_CYC_INTCAL = 4'h3;

	localparam logic [SCT_RETIRE_W-1:0] SCT_RETIRE_RST = 16'h0000;
	localparam logic [SCT_RETIRE_W-1:0] SCT_RETIRE_ONE = 16'h0001;
	localparam logic [SCT_CYC_W-1:0]    SCT_IDX_ONE    = 4'h1;
	localparam logic [SCT_CYC_W-1:0]    SCT_IDX_RST    = 4'h0;

	// timing classes: bytes and cycles
	typedef enum logic [3:0] {
		SCT_B1C1   = 4'h0,
		SCT_B1C2   = 4'h1,
		SCT_B2C2   = 4'h2,
		SCT_B3C3   = 4'h3,
		SCT_B1C3   = 4'h4,
		SCT_B2C3   = 4'h5,
		SCT_B1C4   = 4'h6,
		SCT_B3C4   = 4'h7,
		SCT_MULDIV = 4'h8,
		SCT_XMOVE  = 4'h9,
		SCT_INTCAL = 4'hA
	} sct_class_type;

	typedef enum logic [1:0] {
		SCT_IDLE = 2'h0,
		SCT_EXEC = 2'h1
	} sct_state_type;

endpackage

// ---- sct_timing_if.sv ----
// carries a timing class to the lookup table and its length and time back
// assumes both ends run on the core clock; the path is combinational
`timescale 1ns/1ns
interface sct_timing_if;
	import sct_pkg::*;

	sct_class_type                 timingClass;
	logic [SCT_WAIT_W-1:0]         waitCount;
	logic [SCT_LEN_W-1:0]          instrBytes;
	logic [SCT_CYC_W-1:0]          instrCycles;

	modport table_end (
		input  timingClass,
		input  waitCount,
		output instrBytes,
		output instrCycles
	);

	modport core_end (
		output timingClass,
		output waitCount,
		input  instrBytes,
		input  instrCycles
	);

endinterface

// ---- sct_class_table.sv ----
// turns a timing class into byte length and clock count
// assumes the wait count, passed through unregistered by the sequencer, is synchronous to clk_sys
`timescale 1ns/1ns
module sct_class_table
	import sct_pkg::*;
(
	sct_timing_if.table_end tbl
);

	always_comb begin
		tbl.instrBytes  = SCT_LEN_1;
		tbl.instrCycles = SCT_CYC_1;
		case (tbl.timingClass)
			SCT_B1C1: begin
				tbl.instrBytes  = SCT_LEN_1;
				tbl.instrCycles = SCT_CYC_1;
			end
			SCT_B1C2: begin
				tbl.instrBytes  = SCT_LEN_1;
				tbl.instrCycles = SCT_CYC_2;
			end
			SCT_B2C2: begin
				tbl.instrBytes  = SCT_LEN_2;
				tbl.instrCycles = SCT_CYC_2;
			end
			SCT_B3C3: begin
				tbl.instrBytes  = SCT_LEN_3;
				tbl.instrCycles = SCT_CYC_3;
			end
			SCT_B1C3: begin
				tbl.instrBytes  = SCT_LEN_1;
				tbl.instrCycles = SCT_CYC_3;
			end
			SCT_B2C3: begin
				tbl.instrBytes  = SCT_LEN_2;
				tbl.instrCycles = SCT_CYC_3;
			end
			SCT_B1C4: begin
				tbl.instrBytes  = SCT_LEN_1;
				tbl.instrCycles = SCT_CYC_4;
			end
			SCT_B3C4: begin
				tbl.instrBytes  = SCT_LEN_3;
				tbl.instrCycles = SCT_CYC_4;
			end
			SCT_MULDIV: begin
				tbl.instrBytes  = SCT_LEN_1;
				tbl.instrCycles = SCT_CYC_MULDIV;
			end
			SCT_XMOVE: begin
				tbl.instrBytes  = SCT_LEN_1;
				// four clocks plus one per wait state
				tbl.instrCycles = SCT_CYC_XMOVE
					+ {1'b0, tbl.waitCount};
			end
			SCT_INTCAL: begin
				// inserted call fetches no code bytes
				tbl.instrBytes  = SCT_LEN_0;
				tbl.instrCycles = SCT_CYC_INTCAL;
			end
			default: begin
				tbl.instrBytes  = SCT_LEN_1;
				tbl.instrCycles = SCT_CYC_1;
			end
		endcase
	end

endmodule

// ---- sct_timing_core.sv ----
// instruction length and clock-count sequencer of the single-cycle core
// assumes opcode, request and wait count are synchronous to clk_sys
`timescale 1ns/1ns
module sct_timing_core
	import sct_pkg::*;
(
	input  wire logic                    clk_sys,
	input  wire logic                    reset,
	input  wire logic                    instrValid,
	input  wire logic [SCT_OPC_W-1:0]    opcode,
	input  wire logic                    interruptCall,
	input  wire logic [SCT_WAIT_W-1:0]   external_move_wait_count,
	output logic                         ready,
	output logic                         busy,
	output logic                         firstCycle,
	output logic                         lastCycle,
	output logic [SCT_CYC_W-1:0]         cycleIndex,
	output logic [SCT_LEN_W-1:0]         instrLength,
	output logic [SCT_CYC_W-1:0]         instrCycles,
	output logic [SCT_RETIRE_W-1:0]      retiredCount
);

	typedef struct packed {
		sct_state_type               state;
		logic                        ready;
		logic                        busy;
		logic                        first;
		logic                        last;
		logic [SCT_CYC_W-1:0]        remain;
		logic [SCT_CYC_W-1:0]        index;
		logic [SCT_LEN_W-1:0]        length;
		logic [SCT_CYC_W-1:0]        cycles;
		logic [SCT_RETIRE_W-1:0]     retired;
	} sct_core_type;

	localparam sct_core_type SCT_CORE_RST = '{
		state:   SCT_IDLE,
		ready:   1'b0,
		busy:    1'b0,
		first:   1'b0,
		last:    1'b0,
		remain:  SCT_IDX_RST,
		index:   SCT_IDX_RST,
		length:  SCT_LEN_0,
		cycles:  SCT_IDX_RST,
		retired: SCT_RETIRE_RST
	};

	sct_core_type s;
	sct_core_type next_s;
	logic         acceptNow;

	sct_timing_if tim ();

	// opcode map of the classic 8-bit instruction set
	function automatic sct_class_type classify(input logic [7:0] op);
		sct_class_type c;
		c = SCT_B1C1;
		casez (op)
			8'h00: c = SCT_B1C1;
			8'b????0001: c = SCT_B2C3;
			8'h02: c = SCT_B3C4;
			8'h12: c = SCT_B3C4;
			8'h03, 8'h13, 8'h23, 8'h33: c = SCT_B1C1;
			8'h04, 8'h14: c = SCT_B1C1;
			8'h05, 8'h15: c = SCT_B2C2;
			8'b000?011?: c = SCT_B1C2;
			8'b000?1???: c = SCT_B1C1;
			8'h10, 8'h20, 8'h30: c = SCT_B3C4;
			8'h22, 8'h32: c = SCT_B1C4;
			// add and add with carry
			8'h24, 8'h34: c = SCT_B2C2;
			8'h25, 8'h35: c = SCT_B2C2;
			8'b001?011?: c = SCT_B1C2;
			8'b001?1???: c = SCT_B1C1;
			// relative jumps on carry, zero and always
			8'h40, 8'h50, 8'h60, 8'h70: c = SCT_B2C3;
			8'h80: c = SCT_B2C3;
			// or, and, exclusive or
			8'h42, 8'h52, 8'h62: c = SCT_B2C2;
			8'h43, 8'h53, 8'h63: c = SCT_B3C3;
			8'h44, 8'h54, 8'h64: c = SCT_B2C2;
			8'h45, 8'h55, 8'h65: c = SCT_B2C2;
			8'h46, 8'h47, 8'h56, 8'h57: c = SCT_B1C2;
			8'h66, 8'h67: c = SCT_B1C2;
			8'b01001???, 8'b01011???: c = SCT_B1C1;
			8'b01101???: c = SCT_B1C1;
			8'h72, 8'h82: c = SCT_B2C2;
			8'h73: c = SCT_B1C3;
			8'h74: c = SCT_B2C2;
			8'h75: c = SCT_B3C3;
			8'b0111011?: c = SCT_B2C2;
			8'b01111???: c = SCT_B2C2;
			8'h83, 8'h93: c = SCT_B1C4;
			8'h84, 8'hA4: c = SCT_MULDIV;
			8'h85: c = SCT_B3C3;
			8'b1000011?: c = SCT_B2C2;
			8'b10001???: c = SCT_B2C2;
			8'h90: c = SCT_B3C3;
			8'h92: c = SCT_B2C2;
			// subtract with borrow
			8'h94: c = SCT_B2C2;
			8'h95: c = SCT_B2C2;
			8'b1001011?: c = SCT_B1C2;
			8'b10011???: c = SCT_B1C1;
			8'hA0, 8'hA2, 8'hB0: c = SCT_B2C2;
			8'hA3: c = SCT_B1C3;
			8'hA5: c = SCT_B1C1;
			8'b1010011?: c = SCT_B2C2;
			8'b10101???: c = SCT_B2C2;
			8'hB2: c = SCT_B2C2;
			8'hB3: c = SCT_B1C1;
			8'hB4, 8'hB5: c = SCT_B3C4;
			8'b1011011?: c = SCT_B3C4;
			8'b10111???: c = SCT_B3C4;
			8'hC0, 8'hD0: c = SCT_B2C2;
			8'hC2, 8'hD2: c = SCT_B2C2;
			8'hC3, 8'hD3: c = SCT_B1C1;
			8'hC4: c = SCT_B1C1;
			8'hC5: c = SCT_B2C2;
			8'b1100011?: c = SCT_B1C2;
			8'b11001???: c = SCT_B1C1;
			8'hD4: c = SCT_B1C2;
			8'hD5: c = SCT_B3C4;
			8'b1101011?: c = SCT_B1C2;
			8'b11011???: c = SCT_B2C3;
			// external data moves, both widths and directions
			8'hE0, 8'hF0: c = SCT_XMOVE;
			8'b111?001?: c = SCT_XMOVE;
			8'hE4, 8'hF4: c = SCT_B1C1;
			8'hE5, 8'hF5: c = SCT_B2C2;
			8'b111?011?: c = SCT_B1C2;
			8'b111?1???: c = SCT_B1C1;
			default: c = SCT_B1C1;
		endcase
		return c;
	endfunction

	assign acceptNow = s.ready && instrValid;

	always_comb begin
		tim.timingClass = interruptCall ? SCT_INTCAL
			: classify(opcode);
		tim.waitCount   = external_move_wait_count;
	end

	sct_class_table u_table (
		.tbl (tim.table_end)
	);

	// one step of the count per core clock
	always_comb begin
		next_s       = s;
		next_s.first = 1'b0;
		next_s.last  = 1'b0;
		if (s.last) begin
			next_s.retired = s.retired + SCT_RETIRE_ONE;
		end
		case (s.state)
			SCT_IDLE: begin
				next_s.ready  = 1'b1;
				next_s.remain = SCT_IDX_RST;
				next_s.index  = SCT_IDX_RST;
			end
			SCT_EXEC: begin
				if (s.remain == SCT_IDX_ONE) begin
					next_s.state  = SCT_IDLE;
					next_s.ready  = 1'b1;
					next_s.remain = SCT_IDX_RST;
					next_s.index  = SCT_IDX_RST;
				end else begin
					next_s.remain = s.remain - SCT_IDX_ONE;
					next_s.index  = s.index + SCT_IDX_ONE;
					next_s.last   = (s.remain == SCT_CYC_2);
					next_s.ready  = (s.remain == SCT_CYC_2);
				end
			end
			default: begin
				next_s.state = SCT_IDLE;
				next_s.ready = 1'b0;
			end
		endcase
		// a new instruction starts in the cycle after it is taken
		if (acceptNow) begin
			next_s.state  = SCT_EXEC;
			next_s.first  = 1'b1;
			next_s.index  = SCT_IDX_RST;
			next_s.remain = tim.instrCycles;
			next_s.cycles = tim.instrCycles;
			next_s.length = tim.instrBytes;
			next_s.last   = (tim.instrCycles == SCT_CYC_1);
			next_s.ready  = (tim.instrCycles == SCT_CYC_1);
		end
		// busy output straight from its own flip-flop
		next_s.busy = (next_s.state == SCT_EXEC);
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s <= SCT_CORE_RST;
		end else begin
			s <= next_s;
		end
	end

	assign ready        = s.ready;
	assign busy         = s.busy;
	assign firstCycle   = s.first;
	assign lastCycle    = s.last;
	assign cycleIndex   = s.index;
	assign instrLength  = s.length;
	assign instrCycles  = s.cycles;
	assign retiredCount = s.retired;

endmodule

// ---- sct_timing_monitor.sv ----
// assertions on the ports of the instruction timing core
// assumes one core clock and a synchronous active-high reset
`timescale 1ns/1ns
module sct_timing_monitor
	import sct_pkg::*;
(
	input wire logic                    clk_sys,
	input wire logic                    reset,
	input wire logic                    instrValid,
	input wire logic [SCT_OPC_W-1:0]    opcode,
	input wire logic                    interruptCall,
	input wire logic [SCT_WAIT_W-1:0]   external_move_wait_count,
	input wire logic                    ready,
	input wire logic                    busy,
	input wire logic                    firstCycle,
	input wire logic                    lastCycle,
	input wire logic [SCT_CYC_W-1:0]    cycleIndex,
	input wire logic [SCT_LEN_W-1:0]    instrLength,
	input wire logic [SCT_CYC_W-1:0]    instrCycles,
	input wire logic [SCT_RETIRE_W-1:0] retiredCount
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	sequence s_take;
		ready && instrValid;
	endsequence
	sequence s_first;
		firstCycle && busy && cycleIndex == SCT_IDX_RST;
	endsequence

	a_take_starts: assert property (s_take |=> s_first)
		else $error("no first cycle after take");
	a_last_index: assert property (lastCycle |->
		cycleIndex == instrCycles - SCT_IDX_ONE)
		else $error("last cycle at wrong index");
	a_last_ready: assert property (lastCycle |-> ready && busy)
		else $error("not ready in last cycle");
	a_busy_refuse: assert property (busy && !lastCycle |-> !ready)
		else $error("ready in mid execution");
	a_index_step: assert property (busy && !lastCycle |=>
		busy && cycleIndex == $past(cycleIndex) + SCT_IDX_ONE)
		else $error("cycle index did not step");
	a_retire_step: assert property (lastCycle |=>
		retiredCount == $past(retiredCount) + SCT_RETIRE_ONE)
		else $error("retired count did not step");
	a_irq_call: assert property (s_take ##0 interruptCall |=>
		instrCycles == SCT_CYC_INTCAL && instrLength == SCT_LEN_0)
		else $error("inserted call timing wrong");
	a_xmove_wait: assert property (s_take ##0 (!interruptCall &&
		opcode inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3}) |=>
		instrCycles == SCT_CYC_XMOVE + $past(external_move_wait_count))
		else $error("external move not stretched");
	a_one_cycle: assert property (s_take ##0 (!interruptCall &&
		opcode == 8'h33) |=> firstCycle && lastCycle)
		else $error("rotate not single cycle");
endmodule

bind sct_timing_core sct_timing_monitor mon (.clk_sys, .reset, .instrValid,
	.opcode, .interruptCall, .external_move_wait_count, .ready, .busy,
	.firstCycle, .lastCycle, .cycleIndex, .instrLength, .instrCycles,
	.retiredCount);

// ---- sct_timing_core_tb.sv ----
// self-checking bench for the instruction timing core
// assumes the monitor is bound to the core by its own file
`timescale 1ns/1ns
module sct_timing_core_tb
	import sct_pkg::*;
;
	logic                    clk_sys;
	logic                    reset;
	logic                    instrValid;
	logic [SCT_OPC_W-1:0]    opcode;
	logic                    interruptCall;
	logic [SCT_WAIT_W-1:0]   external_move_wait_count;
	logic                    ready;
	logic                    busy;
	logic                    firstCycle;
	logic                    lastCycle;
	logic [SCT_CYC_W-1:0]    cycleIndex;
	logic [SCT_LEN_W-1:0]    instrLength;
	logic [SCT_CYC_W-1:0]    instrCycles;
	logic [SCT_RETIRE_W-1:0] retiredCount;
	int                      n_errors;
	int                      check_count;

	sct_timing_core dut (.clk_sys, .reset, .instrValid, .opcode,
		.interruptCall, .external_move_wait_count, .ready, .busy,
		.firstCycle, .lastCycle, .cycleIndex, .instrLength,
		.instrCycles, .retiredCount);

	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one instruction, then one idle cycle for the retire count
	task automatic op(input logic [7:0] opc, input logic [1:0] eLen,
			input logic [3:0] eCyc);
		int n;
		logic [15:0] r0;
		@(posedge clk_sys);
		opcode     <= opc;
		instrValid <= 1'h1;
		n = 0;
		@(negedge clk_sys);
		while (ready !== 1'h1 && n < 50) begin
			@(negedge clk_sys);
			n++;
		end
		chk(16'(ready), 16'h0001);
		r0 = retiredCount;
		@(posedge clk_sys);
		instrValid <= 1'h0;
		@(negedge clk_sys);
		chk(16'(firstCycle), 16'h0001);
		chk(16'(instrLength), 16'(eLen));
		chk(16'(instrCycles), 16'(eCyc));
		n = 1;
		while (lastCycle !== 1'h1 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		chk(16'(n), 16'(eCyc));
		@(negedge clk_sys);
		chk(retiredCount, r0 + 16'h0001);
	endtask

	task automatic t_arith();
		op(8'h38, 2'h1, 4'h1);
		op(8'h26, 2'h1, 4'h2);
		op(8'h25, 2'h2, 4'h2);
		op(8'h94, 2'h2, 4'h2);
		op(8'hA3, 2'h1, 4'h3);
		op(8'h53, 2'h3, 4'h3);
		op(8'h33, 2'h1, 4'h1);
		op(8'hE4, 2'h1, 4'h1);
		op(8'hF4, 2'h1, 4'h1);
		op(8'hC4, 2'h1, 4'h1);
		op(8'h75, 2'h3, 4'h3);
		op(8'h90, 2'h3, 4'h3);
		op(8'h93, 2'h1, 4'h4);
		op(8'h83, 2'h1, 4'h4);
	endtask

	task automatic t_xmove();
		op(8'hE0, 2'h1, 4'h4);
		op(8'hE2, 2'h1, 4'h4);
		op(8'hF0, 2'h1, 4'h4);
		op(8'hF2, 2'h1, 4'h4);
		for (int w = 0; w < 8; w++) begin
			@(posedge clk_sys);
			external_move_wait_count <= 3'(w);
			op(8'hE3, 2'h1, 4'(4 + w));
		end
	endtask

	// wait count stays at 7 here: non-moves must not stretch
	task automatic t_misc();
		op(8'hC0, 2'h2, 4'h2);
		op(8'hD0, 2'h2, 4'h2);
		op(8'hD6, 2'h1, 4'h2);
		op(8'h82, 2'h2, 4'h2);
		op(8'hB0, 2'h2, 4'h2);
		op(8'h72, 2'h2, 4'h2);
		op(8'hA0, 2'h2, 4'h2);
		op(8'hA2, 2'h2, 4'h2);
		op(8'h92, 2'h2, 4'h2);
	endtask

	task automatic t_branch();
		op(8'h73, 2'h1, 4'h3);
		op(8'h22, 2'h1, 4'h4);
		op(8'h32, 2'h1, 4'h4);
		op(8'h11, 2'h2, 4'h3);
		op(8'h01, 2'h2, 4'h3);
		op(8'h80, 2'h2, 4'h3);
		op(8'h40, 2'h2, 4'h3);
		op(8'h50, 2'h2, 4'h3);
		op(8'h60, 2'h2, 4'h3);
		op(8'h70, 2'h2, 4'h3);
		op(8'hD8, 2'h2, 4'h3);
		op(8'h02, 2'h3, 4'h4);
		op(8'h12, 2'h3, 4'h4);
		op(8'h20, 2'h3, 4'h4);
		op(8'h30, 2'h3, 4'h4);
		op(8'h10, 2'h3, 4'h4);
		op(8'hB5, 2'h3, 4'h4);
		op(8'hB4, 2'h3, 4'h4);
		op(8'hB8, 2'h3, 4'h4);
		op(8'hB6, 2'h3, 4'h4);
		op(8'hD5, 2'h3, 4'h4);
	endtask

	// inserted call ignores the opcode, even a one-cycle one
	task automatic t_irq();
		@(posedge clk_sys);
		interruptCall <= 1'h1;
		op(8'h12, 2'h0, 4'h3);
		op(8'h33, 2'h0, 4'h3);
		@(posedge clk_sys);
		interruptCall <= 1'h0;
		op(8'h12, 2'h3, 4'h4);
	endtask

	// request held high: refused mid-run, taken in the last cycle
	task automatic t_b2b();
		@(posedge clk_sys);
		opcode     <= 8'hA3;
		instrValid <= 1'h1;
		@(negedge clk_sys);
		while (ready !== 1'h1) @(negedge clk_sys);
		@(posedge clk_sys);
		opcode <= 8'h33;
		@(negedge clk_sys);
		chk(16'(instrCycles), 16'h0003);
		@(negedge clk_sys);
		chk(16'(ready), 16'h0000);
		@(negedge clk_sys);
		chk(16'(lastCycle), 16'h0001);
		@(posedge clk_sys);
		instrValid <= 1'h0;
		@(negedge clk_sys);
		chk(16'({firstCycle, lastCycle}), 16'h0003);
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		#300000;
		n_errors++;
		final_report();
	end

	initial begin
		reset = 1'h1;
		instrValid = 1'h0;
		opcode = 8'h00;
		interruptCall = 1'h0;
		external_move_wait_count = 3'h0;
		n_errors = 0;
		check_count = 0;
		repeat (20) @(posedge clk_sys);
		reset <= 1'h0;
		@(negedge clk_sys);
		chk(16'(busy), 16'h0000);
		chk(retiredCount, 16'h0000);
		chk(16'(ready), 16'h0000);
		t_arith();
		$display("test arith done");
		t_xmove();
		$display("test xmove done");
		t_misc();
		$display("test misc done");
		t_branch();
		$display("test branch done");
		t_irq();
		$display("test irq done");
		t_b2b();
		$display("test b2b done");
		final_report();
	end
endmodule
